// *** sdc_pkg.sv ***
// Package of constants and types for the SDRAM command interface block.
package sdc_pkg;
   localparam int SDC_ROW_W = 13;
   localparam int SDC_COL_W = 12;
   localparam int SDC_BANKS = 4;
   localparam int SDC_DQ_W = 16;
   localparam int SDC_DQM_W = 2;
   localparam int SDC_MODE_W = 14;
   localparam int SDC_AP_BIT = 10;
   localparam logic [SDC_MODE_W-1:0] SDC_MODE_RST = 14'h0000;
   localparam int SDC_CLK_MHZ = 40;
   localparam int SDC_TRP_NS = 20;
   localparam int SDC_TRP_CYC = (SDC_TRP_NS * SDC_CLK_MHZ + 999) / 1000;
   localparam int SDC_DQZ_CYC = 2;
   localparam logic [7:0] SDC_BURST_LEN = 8'h04;
   localparam int SDC_SREF_TICK = 312;
   // Encoded commands on {ras_n, cas_n, we_n}.
   typedef enum logic [2:0] {
      SDC_CMD_NOP = 3'h7,
      SDC_CMD_ACT = 3'h3,
      SDC_CMD_RD = 3'h5,
      SDC_CMD_WR = 3'h4,
      SDC_CMD_BST = 3'h6,
      SDC_CMD_PRE = 3'h2,
      SDC_CMD_REF = 3'h1,
      SDC_CMD_MRS = 3'h0
   } sdc_cmd_t;
   typedef enum logic [2:0] {
      SDC_ST_IDLE = 3'h1,
      SDC_ST_READ = 3'h2,
      SDC_ST_WRITE = 3'h4
   } sdc_burst_t;
endpackage

// *** sdc_buf_if.sv ***
// Interface carrying read data words between the core and its output buffer.
`timescale 1ns/1ps
`default_nettype none
interface sdc_buf_if;
   logic in_valid;
   logic in_ready;
   logic [15:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [15:0] out_data;
   modport src (output in_valid, output in_data, input in_ready);
   modport buf_side (input in_valid, input in_data, output in_ready,
      output out_valid, output out_data, input out_ready);
   modport snk (input out_valid, input out_data, output out_ready);
endinterface
`default_nettype wire

// *** sdc_skid_buf.sv ***
// Two-entry buffer for read data with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sdc_skid_buf (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Buffer ports.
   sdc_buf_if.buf_side bif
);
   logic [15:0] mem_ff [2];
   logic wp_ff;
   logic rp_ff;
   logic [1:0] cnt_ff;
   wire push = bif.in_valid && bif.in_ready;
   wire pop = bif.out_valid && bif.out_ready;

   // Ready drops when both entries hold data so the source stalls.
   assign bif.in_ready = (cnt_ff != 2'h2);
   assign bif.out_valid = (cnt_ff != 2'h0);
   assign bif.out_data = mem_ff[rp_ff];

   // Pointer and occupancy update.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         if (push) wp_ff <= ~wp_ff;
         if (pop) rp_ff <= ~rp_ff;
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end

   // Storage carries no reset; valid gates it.
   always_ff @(posedge core_clk) begin
      if (push) mem_ff[wp_ff] <= bif.in_data;
   end
endmodule
`default_nettype wire

// *** sdc_core.sv ***
// SDRAM command decoder with bank, burst, refresh and mask handling.
`timescale 1ns/1ps
`default_nettype none
module sdc_core
   import sdc_pkg::*;
#(
   parameter bit AUTOMOTIVE = 1'b0
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Command pins.
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [sdc_pkg::SDC_ROW_W-1:0] addr,
   // Data pins and mask.
   input wire logic [sdc_pkg::SDC_DQM_W-1:0] dqm,
   input wire logic [sdc_pkg::SDC_DQ_W-1:0] dq_i,
   output logic [sdc_pkg::SDC_DQ_W-1:0] dq_o,
   output logic [sdc_pkg::SDC_DQM_W-1:0] dq_oe,
   // Array side: read data arrives as a stream, writes leave with a lane mask.
   output logic arr_wr,
   output logic [1:0] arr_bank,
   output logic [sdc_pkg::SDC_ROW_W-1:0] arr_row,
   output logic [sdc_pkg::SDC_COL_W-1:0] arr_col,
   output logic [sdc_pkg::SDC_DQM_W-1:0] arr_wr_lanes,
   output logic [sdc_pkg::SDC_DQ_W-1:0] arr_wdata,
   input wire logic rd_valid,
   input wire logic [sdc_pkg::SDC_DQ_W-1:0] rd_data,
   output logic rd_ready,
   output logic arr_rd,
   // Refresh side.
   output logic ref_pulse,
   output logic [sdc_pkg::SDC_ROW_W-1:0] ref_row,
   // Status.
   output logic [sdc_pkg::SDC_MODE_W-1:0] mode_reg,
   output logic [sdc_pkg::SDC_BANKS-1:0] bank_open,
   output logic [sdc_pkg::SDC_BANKS-1:0] bank_ready,
   output logic in_self_refresh
);
   import sdc_pkg::*;

   sdc_buf_if bif ();
   sdc_skid_buf u_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .bif(bif)
   );

   logic [SDC_MODE_W-1:0] mode_ff;
   logic [SDC_BANKS-1:0] open_ff;
   logic [SDC_ROW_W-1:0] row_ff [SDC_BANKS];
   logic [3:0] trp_ff [SDC_BANKS];
   sdc_burst_t bst_ff, nxt_bst;
   logic [1:0] bbank_ff;
   logic [SDC_COL_W-1:0] col_ff;
   logic [7:0] left_ff;
   logic ap_ff;
   logic sref_ff;
   logic [SDC_ROW_W-1:0] refrow_ff;
   logic [8:0] tick_ff;
   logic [SDC_DQM_W-1:0] dqm_d1_ff;
   logic rdv_d1_ff;
   logic [SDC_DQ_W-1:0] dq_o_ff;
   logic [SDC_DQM_W-1:0] oe_ff;

   // Plain decode of the command pins; a deselected or sleeping device sees a no-op.
   function automatic logic is_cmd(input logic [2:0] code, input sdc_cmd_t c);
      return code == c;
   endfunction

   wire [2:0] pins = {ras_n, cas_n, we_n};
   wire live = !cs_n && !sref_ff;
   wire c_act = live && cke && is_cmd(pins, SDC_CMD_ACT);
   wire c_rd = live && cke && is_cmd(pins, SDC_CMD_RD);
   wire c_wr = live && cke && is_cmd(pins, SDC_CMD_WR);
   wire c_bst = live && cke && is_cmd(pins, SDC_CMD_BST);
   wire c_pre = live && cke && is_cmd(pins, SDC_CMD_PRE);
   wire c_mrs = live && cke && is_cmd(pins, SDC_CMD_MRS);
   wire c_ref = live && cke && is_cmd(pins, SDC_CMD_REF);
   wire c_sre = live && !cke && is_cmd(pins, SDC_CMD_REF) && !AUTOMOTIVE;
   wire a10 = addr[SDC_AP_BIT];
   wire pre_all = c_pre && a10;
   wire [SDC_BANKS-1:0] bank_sel = 4'h1 << ba;
   wire burst_busy = (bst_ff != SDC_ST_IDLE);
   wire burst_last = burst_busy && (left_ff == 8'h01);
   wire new_burst = c_rd || c_wr;
   wire cut_burst = c_bst || (burst_last && !new_burst);
   // Gated by a running burst so a stale auto precharge flag never closes a bank later.
   wire ap_close = cut_burst && ap_ff && burst_busy;
   wire [SDC_BANKS-1:0] close_mask =
      (pre_all ? {SDC_BANKS{1'b1}} : (c_pre ? bank_sel : 4'h0)) |
      (ap_close ? (4'h1 << bbank_ff) : 4'h0);
   wire ready_now [SDC_BANKS];

   // Burst sequencer: a new column command replaces whatever ran before.
   always_comb begin
      nxt_bst = bst_ff;
      case (bst_ff)
         SDC_ST_IDLE, SDC_ST_READ, SDC_ST_WRITE: begin
            if (c_rd) nxt_bst = SDC_ST_READ;
            else if (c_wr) nxt_bst = SDC_ST_WRITE;
            else if (cut_burst) nxt_bst = SDC_ST_IDLE;
         end
         default: nxt_bst = SDC_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bst_ff <= SDC_ST_IDLE;
         left_ff <= 8'h00;
         ap_ff <= 1'b0;
         bbank_ff <= 2'h0;
         col_ff <= '0;
      end else begin
         bst_ff <= nxt_bst;
         if (new_burst) begin
            left_ff <= SDC_BURST_LEN;
            ap_ff <= a10;
            bbank_ff <= ba;
            col_ff <= addr[SDC_COL_W-1:0];
         end else if (burst_busy) begin
            left_ff <= left_ff - 8'h01;
            col_ff <= col_ff + 12'h001;
         end
      end
   end

   // Mode register load takes the op code with the bank bits on top.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) mode_ff <= SDC_MODE_RST;
      else if (c_mrs) mode_ff <= {ba, addr[11:0]};
   end

   // Bank rows and precharge timers; a row stays open until closed.
   for (genvar b = 0; b < SDC_BANKS; b++) begin : g_bank
      assign ready_now[b] = (trp_ff[b] == 4'h0);
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            open_ff[b] <= 1'b0;
            trp_ff[b] <= 4'h0;
            row_ff[b] <= '0;
         end else if (close_mask[b]) begin
            open_ff[b] <= 1'b0;
            trp_ff[b] <= 4'(SDC_TRP_CYC);
         end else begin
            if (c_act && ba == 2'(b) && ready_now[b]) begin
               open_ff[b] <= 1'b1;
               row_ff[b] <= addr;
            end
            if (!ready_now[b]) trp_ff[b] <= trp_ff[b] - 4'h1;
         end
      end
      assign bank_ready[b] = ready_now[b] && !open_ff[b];
   end

   // Self refresh runs on a divided tick; only CKE rising ends it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sref_ff <= 1'b0;
         tick_ff <= 9'h000;
         refrow_ff <= '0;
      end else begin
         if (c_sre) sref_ff <= 1'b1;
         else if (sref_ff && cke) sref_ff <= 1'b0;
         if (sref_ff) tick_ff <= (tick_ff == 9'(SDC_SREF_TICK - 1)) ? 9'h000 : tick_ff + 9'h001;
         else tick_ff <= 9'h000;
         if (ref_pulse) refrow_ff <= refrow_ff + 13'h0001;
      end
   end
   // Both refresh paths step the same row counter; address pins are unused.
   assign ref_pulse = c_ref || (sref_ff && tick_ff == 9'(SDC_SREF_TICK - 1));

   // Read mask and data pipeline: lanes follow the mask two clocks later.
   assign arr_rd = (bst_ff == SDC_ST_READ);
   // Words are taken only while the burst runs, so the buffer drains in the burst's tail.
   assign bif.in_valid = rd_valid && arr_rd;
   assign bif.in_data = rd_data;
   assign rd_ready = bif.in_ready && arr_rd;
   assign bif.out_ready = rdv_d1_ff;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dqm_d1_ff <= '1;
         rdv_d1_ff <= 1'b0;
         dq_o_ff <= '0;
         oe_ff <= '0;
      end else begin
         dqm_d1_ff <= dqm;
         rdv_d1_ff <= arr_rd;
         if (rdv_d1_ff && bif.out_valid) dq_o_ff <= bif.out_data;
         oe_ff <= (rdv_d1_ff && bif.out_valid) ? ~dqm_d1_ff : '0;
      end
   end
   assign dq_o = dq_o_ff;
   assign dq_oe = oe_ff;

   // Write path: the mask is taken in the same cycle as the data.
   // A read command replaces the write burst, so its cycle is no write beat.
   wire wr_beat = c_wr || (bst_ff == SDC_ST_WRITE && !cut_burst && !c_rd);
   assign arr_wr = wr_beat && (dqm != 2'h3);
   assign arr_wr_lanes = ~dqm;
   assign arr_wdata = dq_i;
   assign arr_bank = c_wr ? ba : bbank_ff;
   assign arr_col = c_wr ? addr[SDC_COL_W-1:0] : col_ff;
   assign arr_row = row_ff[arr_bank];

   assign mode_reg = mode_ff;
   assign bank_open = open_ff;
   assign in_self_refresh = sref_ff;
   assign ref_row = refrow_ff;

   // Checks beside the logic.
   a_precharge_all: assert property (@(posedge core_clk) disable iff (!rst_n)
      pre_all |=> open_ff == 4'h0) else $error("precharge all left a bank open");
   a_mode_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      c_mrs |=> mode_ff == $past({ba, addr[11:0]})) else $error("mode not loaded");
   a_deselect_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      cs_n |=> $stable(open_ff) || $past(ap_close)) else $error("deselect changed banks");
   a_dqm_high_z: assert property (@(posedge core_clk) disable iff (!rst_n)
      dqm == 2'h3 |-> ##2 dq_oe == 2'h0) else $error("masked lane driven");
   a_write_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
      dqm == 2'h3 |-> !arr_wr) else $error("write with full mask");
   a_trp_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      c_pre && !a10 |=> !bank_ready[$past(ba)] [*1]) else $error("bank ready early");
   a_bst_cuts: assert property (@(posedge core_clk) disable iff (!rst_n)
      c_bst |=> bst_ff == SDC_ST_IDLE) else $error("burst not cut");
   a_sref_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      sref_ff && !cke |=> sref_ff) else $error("self refresh left early");
   a_auto_ref: assert property (@(posedge core_clk) disable iff (!rst_n)
      c_ref |=> refrow_ff == $past(refrow_ff) + 13'h0001) else $error("row not advanced");
   a_auto_close: assert property (@(posedge core_clk) disable iff (!rst_n)
      burst_last && ap_ff && !new_burst |=> !open_ff[$past(bbank_ff)])
      else $error("auto precharge missed");
   c_read_burst: cover property (@(posedge core_clk) disable iff (!rst_n)
      c_rd ##[2:6] dq_oe != 2'h0);
   c_write_ap: cover property (@(posedge core_clk) disable iff (!rst_n) c_wr && a10);
   c_sref: cover property (@(posedge core_clk) disable iff (!rst_n) c_sre ##[1:400] ref_pulse);
endmodule
`default_nettype wire

// *** sdc_ctrl_model.sv ***
// Behavioural memory controller model driving the command, mask and data pins.
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model
   import sdc_pkg::*;
(
   // Clock.
   input wire logic core_clk,
   // Command pins, with {ras_n, cas_n, we_n} carried as one code.
   output logic cke,
   output logic cs_n,
   output logic [2:0] rcw,
   output logic [1:0] ba,
   output logic [12:0] addr,
   // Mask and write data.
   output logic [1:0] dqm,
   output logic [15:0] dq_i
);
   int seed = 32'ha265;

   // The device starts deselected with the clock enabled.
   initial begin
      cke = 1'b1;
      cs_n = 1'b1;
      rcw = 3'h7;
      ba = 2'h0;
      addr = 13'h0;
      dqm = 2'h0;
      dq_i = 16'h0;
   end

   // One command for one cycle, then deselect with a fresh random code.
   // The random code checks that the command pins are ignored while the device is deselected.
   task automatic issue(input sdc_cmd_t c, input logic [1:0] b, input logic [12:0] a,
      input logic k);
      @(posedge core_clk);
      cke <= k;
      cs_n <= 1'b0;
      rcw <= c;
      ba <= b;
      addr <= a;
      @(posedge core_clk);
      cs_n <= 1'b1;
      rcw <= 3'($random(seed));
      ba <= 2'($random(seed));
      addr <= 13'($random(seed));
   endtask

   // Deselected cycles whose command pins change on every cycle.
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge core_clk);
         rcw <= 3'($random(seed));
         addr <= 13'($random(seed));
      end
   endtask

   // Mask and data are held until changed again.
   task automatic set_data(input logic [1:0] m, input logic [15:0] d);
      @(posedge core_clk);
      dqm <= m;
      dq_i <= d;
   endtask
endmodule
`default_nettype wire

// *** sdc_core_tb.sv ***
// Self-checking testbench for the SDRAM command decoder core.
`timescale 1ns/1ps
`default_nettype none
module sdc_core_tb;
   import sdc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cke, cs_n, arr_wr, arr_rd, rd_ready, ref_pulse, in_sr;
   logic rd_valid = 1'b0;
   logic [2:0] rcw;
   logic [1:0] ba, dqm, dq_oe, arr_bank, lanes, m;
   logic [12:0] addr, arr_row, ref_row, a, r;
   logic [15:0] dq_i, dq_o, wdata, d, lm;
   logic [15:0] rd_data = 16'h0;
   logic [11:0] col;
   logic [13:0] mode_reg;
   logic [3:0] bank_open, bank_ready;
   logic [15:0] pushed[$];
   int errors = 0;
   int samples_checked = 0;
   int seed = 32'ha265;
   int open_m = 0;
   int rows[4];
   int k, n;
   bit seen, found;

   sdc_ctrl_model u_sdc_ctrl_model (.core_clk(core_clk), .cke(cke), .cs_n(cs_n), .rcw(rcw),
      .ba(ba), .addr(addr), .dqm(dqm), .dq_i(dq_i));
   sdc_core u_sdc_core (.core_clk(core_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
      .ras_n(rcw[2]), .cas_n(rcw[1]), .we_n(rcw[0]), .ba(ba), .addr(addr), .dqm(dqm),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .arr_wr(arr_wr), .arr_bank(arr_bank),
      .arr_row(arr_row), .arr_col(col), .arr_wr_lanes(lanes), .arr_wdata(wdata),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready), .arr_rd(arr_rd),
      .ref_pulse(ref_pulse), .ref_row(ref_row), .mode_reg(mode_reg), .bank_open(bank_open),
      .bank_ready(bank_ready), .in_self_refresh(in_sr));

   // A 40 MHz clock.
   always #12.5 core_clk = ~core_clk;

   // Array stream: words are offered at random and held until the buffer takes them.
   always @(posedge core_clk) begin
      if (rd_valid && rd_ready)
         pushed.push_back(rd_data);
      if (!rd_valid || rd_ready) begin
         // The first word of each read is always offered, so every burst carries data.
         rd_valid <= arr_rd && (pushed.size() == 0 || $random(seed) % 4 != 0);
         rd_data <= 16'($random(seed));
      end
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // A hang is cut after far more cycles than the tests need.
   initial begin
      #(25 * 20000);
      errors++;
      $display("ERROR watchdog expected finish seen timeout");
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      chk("mode_reg", SDC_MODE_RST, mode_reg);
      chk("bank_open", 0, bank_open);
      chk("dq_oe", 0, dq_oe);
      // Mode load with all banks idle, then three deselected cycles before the next command.
      a = 13'($random(seed));
      u_sdc_ctrl_model.issue(SDC_CMD_MRS, 2'h2, a, 1'b1);
      @(negedge core_clk);
      chk("mode_reg", {2'h2, a[11:0]}, mode_reg);
      u_sdc_ctrl_model.idle(2);
      for (k = 0; k < 4; k++) begin
         rows[k] = $random(seed) & 32'h1fff;
         u_sdc_ctrl_model.issue(SDC_CMD_ACT, 2'(k), 13'(rows[k]), 1'b1);
         open_m |= 1 << k;
         @(negedge core_clk);
         chk("bank_open", open_m, bank_open);
      end
      u_sdc_ctrl_model.idle(16);
      @(negedge core_clk);
      chk("bank_open deselected", open_m, bank_open);
      chk("mode_reg deselected", {2'h2, a[11:0]}, mode_reg);
      $display("Test activate finished");
      // Write burst with a random mask, cut short by a stop two cycles later.
      m = 2'($random(seed));
      d = 16'($random(seed));
      a = 13'($random(seed)) & 13'h03fc;
      u_sdc_ctrl_model.set_data(m, d);
      fork
         u_sdc_ctrl_model.issue(SDC_CMD_WR, 2'h0, a, 1'b1);
         begin
            @(posedge core_clk);
            @(negedge core_clk);
            chk("arr_wr", m != 2'h3, arr_wr);
            chk("arr_bank", 0, arr_bank);
            chk("arr_row", rows[0], arr_row);
            chk("arr_col", a[11:0], col);
            chk("arr_wr_lanes", 2'(~m), lanes);
            chk("arr_wdata", d, wdata);
         end
      join
      u_sdc_ctrl_model.issue(SDC_CMD_BST, 2'h3, 13'h0, 1'b1);
      @(negedge core_clk);
      chk("arr_wr after stop", 0, arr_wr);
      chk("bank_open no auto precharge", open_m, bank_open);
      u_sdc_ctrl_model.issue(SDC_CMD_PRE, 2'h0, 13'h0, 1'b1);
      open_m &= ~1;
      @(negedge core_clk);
      chk("bank_open single precharge", open_m, bank_open);
      @(negedge core_clk);
      chk("bank_ready", 1, bank_ready[0]);
      // Write with auto precharge: the bank stays open for the burst, then closes.
      u_sdc_ctrl_model.issue(SDC_CMD_WR, 2'h1, 13'h0400, 1'b1);
      @(negedge core_clk);
      for (n = 0; n < 8 && bank_open[1] === 1'b1; n++)
         @(negedge core_clk);
      chk("auto precharge delay", SDC_BURST_LEN, n);
      chk("bank_open auto precharge", 0, bank_open[1]);
      open_m &= ~2;
      $display("Test write finished");
      // Reads with each mask value; masked lanes never drive.
      for (k = 0; k < 4; k++) begin
         u_sdc_ctrl_model.set_data(2'(k), 16'h0);
         pushed.delete();
         seen = 0;
         u_sdc_ctrl_model.issue(SDC_CMD_RD, 2'h2, 13'h0, 1'b1);
         @(negedge core_clk);
         chk("arr_rd", 1, arr_rd);
         repeat (11) begin
            @(negedge core_clk);
            chk("dq_oe masked", 0, dq_oe & 2'(k));
            if (dq_oe !== 2'h0) begin
               lm = {{8{dq_oe[1]}}, {8{dq_oe[0]}}};
               found = 0;
               foreach (pushed[i])
                  if ((pushed[i] & lm) === (dq_o & lm))
                     found = 1;
               chk("dq_o word", 1, found);
               if (dq_oe === ~2'(k))
                  seen = 1;
            end
         end
         chk("dq_oe driven", k != 3, seen);
      end
      $display("Test read finished");
      // Precharge all, then two auto refreshes with random address.
      u_sdc_ctrl_model.issue(SDC_CMD_PRE, 2'($random(seed)), 13'h0400, 1'b1);
      open_m = 0;
      @(negedge core_clk);
      chk("bank_open all precharge", 0, bank_open);
      u_sdc_ctrl_model.idle(2);
      // The refresh pulse stands only in the cycle in which the command is on the pins.
      r = ref_row;
      for (k = 0; k < 2; k++) begin
         fork
            u_sdc_ctrl_model.issue(SDC_CMD_REF, 2'($random(seed)), 13'($random(seed)), 1'b1);
            begin
               @(posedge core_clk);
               @(negedge core_clk);
               chk("ref_pulse", 1, ref_pulse);
            end
         join
         @(negedge core_clk);
         chk("ref_row step", 13'(r + 13'h1), ref_row);
         r = ref_row;
      end
      // Self refresh: commands ignored, internal refresh runs, exit by clock enable.
      u_sdc_ctrl_model.issue(SDC_CMD_REF, 2'h0, 13'h0, 1'b0);
      @(negedge core_clk);
      chk("in_self_refresh", 1, in_sr);
      u_sdc_ctrl_model.issue(SDC_CMD_ACT, 2'h0, 13'h0, 1'b0);
      @(negedge core_clk);
      chk("bank_open in self refresh", 0, bank_open);
      for (n = 0; n < 330 && ref_pulse !== 1'b1; n++)
         @(negedge core_clk);
      chk("internal refresh", 1, ref_pulse);
      // Spacing of internal refreshes against the distributed schedule, in 25 ns cycles.
      @(negedge core_clk);
      for (n = 1; n < 330 && ref_pulse !== 1'b1; n++)
         @(negedge core_clk);
      chk("refresh spacing", 1, n * 25 <= 7813);
      chk("refresh per window", 1, 8192 * n * 25 <= 64000000);
      u_sdc_ctrl_model.issue(SDC_CMD_NOP, 2'h0, 13'h0, 1'b1);
      @(negedge core_clk);
      chk("in_self_refresh exit", 0, in_sr);
      u_sdc_ctrl_model.idle(3);
      // Auto refresh resumes on the counter that self refresh advanced.
      r = ref_row;
      u_sdc_ctrl_model.issue(SDC_CMD_REF, 2'h0, 13'h0, 1'b1);
      @(negedge core_clk);
      chk("ref_row after exit", 13'(r + 13'h1), ref_row);
      u_sdc_ctrl_model.issue(SDC_CMD_ACT, 2'h3, 13'h0, 1'b1);
      @(negedge core_clk);
      chk("bank_open after exit", 8, bank_open);
      $display("Test refresh finished");
      // A reset in mid-run closes every bank and restores the mode setting.
      @(posedge core_clk);
      rst_n <= 1'b0;
      @(negedge core_clk);
      chk("bank_open in reset", 0, bank_open);
      chk("mode_reg in reset", SDC_MODE_RST, mode_reg);
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      chk("bank_ready after reset", 4'hf, bank_ready);
      chk("in_self_refresh after reset", 0, in_sr);
      $display("Test reset finished");
      end_of_test();
   end
endmodule
`default_nettype wire
